// ==== src/cbl_br_if.sv ====
// Carrier between the executor and its branch condition evaluator
`timescale 1ns/1ps
`default_nettype none
interface cbl_br_if;
    import cbl_pkg::*;
    logic clk;
    logic reset;
    logic [7:0] flags;
    cbl_op_type op;
    logic taken;
    modport exec (output clk, output reset, output flags, output op, input taken);
    modport cond (input clk, input reset, input flags, input op, output taken);
endinterface
`default_nettype wire

// ==== src/cbl_cond.sv ====
// Branch condition evaluator: decides from the status flags whether a branch jumps
`timescale 1ns/1ps
`default_nettype none
`include "cbl_defs.svh"
module cbl_cond
(
    cbl_br_if.cond br
);
    import cbl_pkg::*;

    wire logic f_c = br.flags[`CBL_FLAG_C];
    wire logic f_n = br.flags[`CBL_FLAG_N];
    wire logic f_v = br.flags[`CBL_FLAG_V];
    wire logic f_h = br.flags[`CBL_FLAG_H];
    wire logic f_t = br.flags[`CBL_FLAG_T];
    wire logic f_i = br.flags[`CBL_FLAG_I];
    wire logic signed_lt = f_n ^ f_v;

    // One condition per branch, indexed by the low bits of the branch code
    wire logic [10:0] cond_vec = {
        ~f_i,
        f_i,
        ~f_t,
        f_t,
        ~f_h,
        f_h,
        signed_lt,
        ~signed_lt,
        ~f_n,
        f_n,
        f_c
    };
    wire logic is_branch = br.op[`CBL_OP_BRANCH_BIT];
    wire logic [3:0] sel = br.op[3:0];

    assign br.taken = is_branch && (sel <= 4'hA) && cond_vec[sel];

    carry_cond_a: assert property (@(posedge br.clk) disable iff (br.reset)
        br.op == CBL_BRANCH_ON_CARRY |-> br.taken == br.flags[`CBL_FLAG_C])
        else $error("carry branch condition wrong");
    sign_cond_a: assert property (@(posedge br.clk) disable iff (br.reset)
        (br.op == CBL_BRANCH_NEGATIVE || br.op == CBL_BRANCH_POSITIVE)
        |-> br.taken == (br.flags[`CBL_FLAG_N] ^ (br.op == CBL_BRANCH_POSITIVE)))
        else $error("negative or positive branch condition wrong");
    not_less_a: assert property (@(posedge br.clk) disable iff (br.reset)
        br.op == CBL_BRANCH_SIGNED_NOT_LESS
        |-> br.taken == !(br.flags[`CBL_FLAG_N] ^ br.flags[`CBL_FLAG_V]))
        else $error("signed not-less condition wrong");
    less_cond_a: assert property (@(posedge br.clk) disable iff (br.reset)
        br.op == CBL_BRANCH_SIGNED_LESS
        |-> br.taken == (br.flags[`CBL_FLAG_N] ^ br.flags[`CBL_FLAG_V]))
        else $error("signed less condition wrong");
    half_set_a: assert property (@(posedge br.clk) disable iff (br.reset)
        br.op == CBL_BRANCH_HALF_CARRY_SET |-> br.taken == br.flags[`CBL_FLAG_H])
        else $error("half carry set condition wrong");
    half_clear_a: assert property (@(posedge br.clk) disable iff (br.reset)
        br.op == CBL_BRANCH_HALF_CARRY_CLEAR |-> br.taken == !br.flags[`CBL_FLAG_H])
        else $error("half carry clear condition wrong");
    transfer_set_a: assert property (@(posedge br.clk) disable iff (br.reset)
        br.op == CBL_BRANCH_TRANSFER_SET |-> br.taken == br.flags[`CBL_FLAG_T])
        else $error("transfer set condition wrong");
    transfer_clear_a: assert property (@(posedge br.clk) disable iff (br.reset)
        br.op == CBL_BRANCH_TRANSFER_CLEAR |-> br.taken == !br.flags[`CBL_FLAG_T])
        else $error("transfer clear condition wrong");
    irq_on_a: assert property (@(posedge br.clk) disable iff (br.reset)
        br.op == CBL_BRANCH_IRQ_ON |-> br.taken == br.flags[`CBL_FLAG_I])
        else $error("interrupts-on condition wrong");
    irq_off_a: assert property (@(posedge br.clk) disable iff (br.reset)
        br.op == CBL_BRANCH_IRQ_OFF |-> br.taken == !br.flags[`CBL_FLAG_I])
        else $error("interrupts-off condition wrong");

endmodule
`default_nettype wire

// ==== src/cbl_defs.svh ====
// Bit positions and codes shared by the branch and load execution logic
`ifndef CBL_DEFS_SVH
`define CBL_DEFS_SVH

// Status register bit positions
`define CBL_FLAG_C 0
`define CBL_FLAG_Z 1
`define CBL_FLAG_N 2
`define CBL_FLAG_V 3
`define CBL_FLAG_S 4
`define CBL_FLAG_H 5
`define CBL_FLAG_T 6
`define CBL_FLAG_I 7

// Status register value after reset
`define CBL_FLAGS_RESET 8'h00

// Pointer pair select codes
`define CBL_PTR_X 2'h1
`define CBL_PTR_Y 2'h2
`define CBL_PTR_Z 2'h3

// Operation code bit that marks a conditional branch
`define CBL_OP_BRANCH_BIT 4

`endif

// ==== src/cbl_exec.sv ====
// Executor for conditional relative branches, register copies and indirect loads
`timescale 1ns/1ps
`default_nettype none
`include "cbl_defs.svh"
// Operation
// - Branch on carry jumps to pc plus offset plus one when carry is set.
// - Negative branch jumps when N is one; positive branch when N is zero.
// - Signed not-less branch jumps when N xor V is zero.
// - Signed less branch jumps when N xor V is one.
// - Half-carry-set branch jumps when H is one, else falls through.
// - Half-carry-clear branch jumps when H is zero, else falls through.
// - Transfer-set branch jumps when T is one, else falls through.
// - Transfer-clear branch jumps when T is zero, else falls through.
// - Interrupts-on branch jumps when the global enable is one.
// - Interrupts-off branch jumps when the global enable is zero.
// - Branches never change any status flag, taken or not.
// - Post-increment load reads at pointer, then pointer plus one; two cycles.
// - Pre-decrement load lowers pointer first, then reads there; two cycles.
// - Offset load reads pointer plus unsigned displacement, pointer kept; two cycles.
module cbl_exec
(
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire cbl_pkg::cbl_op_type op,
    input wire logic [15:0] pc,
    input wire logic [6:0] offset,
    input wire logic [4:0] dest,
    input wire logic [15:0] src_data,
    input wire logic [7:0] imm,
    input wire logic [15:0] ptr,
    input wire logic [1:0] ptr_sel,
    input wire logic [5:0] disp,
    input wire logic [7:0] mem_rdata,
    input wire logic alu_flag_we,
    input wire logic [7:0] alu_flags,
    output logic ready,
    output logic done,
    output logic pc_load,
    output logic [15:0] pc_target,
    output logic rf_we,
    output logic rf_wide,
    output logic [4:0] rf_waddr,
    output logic [15:0] rf_wdata,
    output logic ptr_we,
    output logic [1:0] ptr_wsel,
    output logic [15:0] ptr_wdata,
    output logic mem_re,
    output logic [15:0] mem_addr,
    output logic [7:0] flags
);
    import cbl_pkg::*;

    cbl_state_type state_r;
    cbl_state_type state_nxt;
    logic done_r;
    logic pc_load_r;
    logic [15:0] pc_target_r;
    logic rf_we_r;
    logic rf_wide_r;
    logic [4:0] rf_waddr_r;
    logic [15:0] rf_wdata_r;
    logic ptr_we_r;
    logic [1:0] ptr_wsel_r;
    logic [15:0] ptr_wdata_r;
    logic mem_re_r;
    logic [15:0] mem_addr_r;
    logic [7:0] flags_r;

    cbl_br_if br ();
    cbl_cond u_cond (
        .br(br)
    );
    assign br.clk = clk;
    assign br.reset = reset;
    assign br.flags = flags_r;
    assign br.op = op;

    // Decode of the incoming operation
    wire logic accept = start && (state_r == CBL_ST_IDLE);
    wire logic is_branch = op[`CBL_OP_BRANCH_BIT];
    wire logic taken = br.taken;
    wire logic is_copy = (op == CBL_COPY_REGISTER) || (op == CBL_COPY_REGISTER_PAIR)
        || (op == CBL_LOAD_CONSTANT);
    wire logic is_load = (op == CBL_LOAD_INDIRECT) || (op == CBL_LOAD_POST_INC)
        || (op == CBL_LOAD_PRE_DEC) || (op == CBL_LOAD_OFFSET);
    wire logic ptr_changes = (op == CBL_LOAD_POST_INC) || (op == CBL_LOAD_PRE_DEC);

    // Target is relative to the branch's own address; offset is signed
    wire logic [15:0] offset_ext = {{9{offset[6]}}, offset};
    wire logic [15:0] target_calc = pc + offset_ext + 16'h0001;
    wire logic [15:0] ptr_inc = ptr + 16'h0001;
    wire logic [15:0] ptr_dec = ptr - 16'h0001;
    wire logic [15:0] ptr_disp = ptr + {10'h000, disp};
    wire logic [15:0] load_addr = (op == CBL_LOAD_PRE_DEC) ? ptr_dec :
                                  (op == CBL_LOAD_OFFSET) ? ptr_disp : ptr;
    wire logic [15:0] ptr_new = (op == CBL_LOAD_PRE_DEC) ? ptr_dec : ptr_inc;
    wire logic [15:0] copy_data = (op == CBL_LOAD_CONSTANT) ? {8'h00, imm} :
                                  (op == CBL_COPY_REGISTER) ? {8'h00, src_data[7:0]} : src_data;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            CBL_ST_IDLE:
            begin
                if (accept && is_branch && taken)
                begin
                    state_nxt = CBL_ST_BRANCH;
                end
                else if (accept && is_load)
                begin
                    state_nxt = CBL_ST_LOAD;
                end
            end
            CBL_ST_BRANCH:
            begin
                state_nxt = CBL_ST_IDLE;
            end
            CBL_ST_LOAD:
            begin
                state_nxt = CBL_ST_IDLE;
            end
            default:
            begin
                state_nxt = CBL_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_r <= CBL_ST_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Completion: untaken branch and copies end after one cycle, taken branch and loads after two; a no-op never signals done
    wire logic done_nxt = (accept && ((is_branch && !taken) || is_copy))
        || (state_r == CBL_ST_BRANCH) || (state_r == CBL_ST_LOAD);

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            done_r <= 1'b0;
            pc_load_r <= 1'b0;
            pc_target_r <= 16'h0000;
        end
        else
        begin
            done_r <= done_nxt;
            pc_load_r <= (state_r == CBL_ST_BRANCH);
            if (accept && is_branch)
            begin
                pc_target_r <= target_calc;
            end
        end
    end

    // Register file write: copies one cycle after accept, loads once memory data is back
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rf_we_r <= 1'b0;
            rf_wide_r <= 1'b0;
            rf_waddr_r <= 5'h00;
            rf_wdata_r <= 16'h0000;
        end
        else
        begin
            rf_we_r <= (accept && is_copy) || (state_r == CBL_ST_LOAD);
            if (accept && (is_copy || is_load))
            begin
                rf_waddr_r <= dest;
                rf_wide_r <= (op == CBL_COPY_REGISTER_PAIR);
            end
            if (accept && is_copy)
            begin
                rf_wdata_r <= copy_data;
            end
            else if (state_r == CBL_ST_LOAD)
            begin
                rf_wdata_r <= {8'h00, mem_rdata};
            end
        end
    end

    // Memory read and pointer update issue in the first cycle of a load
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mem_re_r <= 1'b0;
            mem_addr_r <= 16'h0000;
            ptr_we_r <= 1'b0;
            ptr_wsel_r <= 2'h0;
            ptr_wdata_r <= 16'h0000;
        end
        else
        begin
            mem_re_r <= accept && is_load;
            ptr_we_r <= accept && ptr_changes;
            if (accept && is_load)
            begin
                mem_addr_r <= load_addr;
                ptr_wsel_r <= ptr_sel;
                ptr_wdata_r <= ptr_new;
            end
        end
    end

    // Only the arithmetic unit writes flags; nothing executed here touches them
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            flags_r <= `CBL_FLAGS_RESET;
        end
        else if (alu_flag_we)
        begin
            flags_r <= alu_flags;
        end
    end

    assign ready = (state_r == CBL_ST_IDLE);
    assign done = done_r;
    assign pc_load = pc_load_r;
    assign pc_target = pc_target_r;
    assign rf_we = rf_we_r;
    assign rf_wide = rf_wide_r;
    assign rf_waddr = rf_waddr_r;
    assign rf_wdata = rf_wdata_r;
    assign ptr_we = ptr_we_r;
    assign ptr_wsel = ptr_wsel_r;
    assign ptr_wdata = ptr_wdata_r;
    assign mem_re = mem_re_r;
    assign mem_addr = mem_addr_r;
    assign flags = flags_r;

    flags_kept_a: assert property (@(posedge clk) disable iff (reset)
        !alu_flag_we |=> flags == $past(flags))
        else $error("flags changed without an arithmetic write");
    branch_untaken_a: assert property (@(posedge clk) disable iff (reset)
        accept && is_branch && !taken |=> done && !pc_load && ready)
        else $error("untaken branch not done in one cycle");
    branch_taken_a: assert property (@(posedge clk) disable iff (reset)
        accept && is_branch && taken
        |=> !done && !ready ##1 done && pc_load && pc_target == $past(target_calc, 2))
        else $error("taken branch target or timing wrong");
    copy_write_a: assert property (@(posedge clk) disable iff (reset)
        accept && is_copy |=> done && rf_we && rf_wdata == $past(copy_data))
        else $error("copy not written in one cycle");
    post_inc_a: assert property (@(posedge clk) disable iff (reset)
        accept && op == CBL_LOAD_POST_INC
        |=> mem_re && mem_addr == $past(ptr) && ptr_we && ptr_wdata == $past(ptr_inc))
        else $error("post-increment address or pointer wrong");
    pre_dec_a: assert property (@(posedge clk) disable iff (reset)
        accept && op == CBL_LOAD_PRE_DEC
        |=> mem_re && mem_addr == $past(ptr_dec) && ptr_wdata == mem_addr)
        else $error("pre-decrement address or pointer wrong");
    offset_load_a: assert property (@(posedge clk) disable iff (reset)
        accept && op == CBL_LOAD_OFFSET
        |=> mem_re && !ptr_we && mem_addr == $past(ptr_disp))
        else $error("offset load address wrong or pointer changed");
    plain_load_a: assert property (@(posedge clk) disable iff (reset)
        accept && op == CBL_LOAD_INDIRECT
        |=> !ptr_we && !done ##1 done && rf_we && rf_wdata[7:0] == $past(mem_rdata))
        else $error("plain load data or timing wrong");

endmodule
`default_nettype wire

// ==== src/cbl_pkg.sv ====
// Types for the branch and load execution logic
package cbl_pkg;

    typedef enum logic [4:0] {
        CBL_NOP = 5'h00,
        CBL_COPY_REGISTER = 5'h01,
        CBL_COPY_REGISTER_PAIR = 5'h02,
        CBL_LOAD_CONSTANT = 5'h03,
        CBL_LOAD_INDIRECT = 5'h04,
        CBL_LOAD_POST_INC = 5'h05,
        CBL_LOAD_PRE_DEC = 5'h06,
        CBL_LOAD_OFFSET = 5'h07,
        CBL_BRANCH_ON_CARRY = 5'h10,
        CBL_BRANCH_NEGATIVE = 5'h11,
        CBL_BRANCH_POSITIVE = 5'h12,
        CBL_BRANCH_SIGNED_NOT_LESS = 5'h13,
        CBL_BRANCH_SIGNED_LESS = 5'h14,
        CBL_BRANCH_HALF_CARRY_SET = 5'h15,
        CBL_BRANCH_HALF_CARRY_CLEAR = 5'h16,
        CBL_BRANCH_TRANSFER_SET = 5'h17,
        CBL_BRANCH_TRANSFER_CLEAR = 5'h18,
        CBL_BRANCH_IRQ_ON = 5'h19,
        CBL_BRANCH_IRQ_OFF = 5'h1A
    } cbl_op_type;

    typedef enum logic [1:0] {
        CBL_ST_IDLE = 2'h0,
        CBL_ST_BRANCH = 2'h1,
        CBL_ST_LOAD = 2'h2
    } cbl_state_type;

endpackage

// ==== test/cbl_mem_model.sv ====
// Data memory model answering reads in the cycle the read strobe is high
`timescale 1ns/1ps
`default_nettype none
module cbl_mem_model
(
    input wire logic clk,
    input wire logic mem_re,
    input wire logic [15:0] mem_addr,
    output logic [7:0] mem_rdata
);
    logic [7:0] junk_r;
    initial junk_r = 8'h3C;
    // Outside a read the bus toggles, so a late sample cannot match by luck
    always @(posedge clk)
    begin
        junk_r <= ~junk_r;
    end
    assign mem_rdata = mem_re ? (mem_addr[7:0] ^ mem_addr[15:8] ^ 8'hA5) : junk_r;
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the branch and load executor
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cbl_pkg::*;
    typedef struct {
        logic tk;
        logic [15:0] pct;
        logic rfw;
        logic wide;
        logic [4:0] wa;
        logic [15:0] wd;
        logic mre;
        logic pwe;
        logic [1:0] ps;
        logic [15:0] pwd;
        logic [15:0] ma;
        int lat;
    } cbl_tb_note_type;
    logic clk, reset, start, alu_flag_we, ready, done, pc_load, rf_we, rf_wide, ptr_we, mem_re;
    cbl_op_type op;
    logic [15:0] pc, src_data, ptr, pc_target, rf_wdata, ptr_wdata, mem_addr, seen_ma, seen_pwd;
    logic [6:0] offset;
    logic [4:0] dest, rf_waddr;
    logic [7:0] imm, mem_rdata, alu_flags, flags, flg;
    logic [1:0] ptr_sel, ptr_wsel, seen_ps;
    logic [5:0] disp;
    logic seen_mre, seen_pwe;
    int fails, n_compared, cyc, seed, i, j;
    cbl_tb_note_type q[$];
    int acc_q[$];
    cbl_exec dut_u (.clk(clk), .reset(reset), .start(start), .op(op), .pc(pc), .offset(offset),
        .dest(dest), .src_data(src_data), .imm(imm), .ptr(ptr), .ptr_sel(ptr_sel), .disp(disp),
        .mem_rdata(mem_rdata), .alu_flag_we(alu_flag_we), .alu_flags(alu_flags), .ready(ready),
        .done(done), .pc_load(pc_load), .pc_target(pc_target), .rf_we(rf_we), .rf_wide(rf_wide),
        .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .ptr_we(ptr_we), .ptr_wsel(ptr_wsel),
        .ptr_wdata(ptr_wdata), .mem_re(mem_re), .mem_addr(mem_addr), .flags(flags));
    cbl_mem_model mem_u (.clk(clk), .mem_re(mem_re), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
    initial clk = 1'b0;
    always #4 clk = ~clk;
    task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        n_compared++;
        if (e !== g)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Flag bits: 7 I, 6 T, 5 H, 4 S, 3 V, 2 N, 1 Z, 0 C
    function automatic logic cond_of(input cbl_op_type o, input logic [7:0] f);
        case (o)
            CBL_BRANCH_ON_CARRY: return f[0];
            CBL_BRANCH_NEGATIVE: return f[2];
            CBL_BRANCH_POSITIVE: return !f[2];
            CBL_BRANCH_SIGNED_NOT_LESS: return !(f[2] ^ f[3]);
            CBL_BRANCH_SIGNED_LESS: return f[2] ^ f[3];
            CBL_BRANCH_HALF_CARRY_SET: return f[5];
            CBL_BRANCH_HALF_CARRY_CLEAR: return !f[5];
            CBL_BRANCH_TRANSFER_SET: return f[6];
            CBL_BRANCH_TRANSFER_CLEAR: return !f[6];
            CBL_BRANCH_IRQ_ON: return f[7];
            default: return !f[7];
        endcase
    endfunction
    // Presents one request and holds it until the design shows ready
    task automatic send(input cbl_op_type o, input logic [15:0] p, input logic [6:0] k);
        cbl_tb_note_type n;
        logic [15:0] s;
        logic [7:0] im;
        logic [5:0] dq;
        logic [1:0] ps;
        int w;
        n = '{default: '0};
        s = 16'($random(seed));
        im = 8'($random(seed));
        dq = 6'($random(seed));
        ps = 2'(($unsigned($random(seed)) % 3) + 1);
        n.wa = 5'($random(seed));
        n.rfw = (o != CBL_NOP) && (o < CBL_BRANCH_ON_CARRY);
        n.lat = 1;
        n.ps = ps;
        case (o)
            CBL_COPY_REGISTER: n.wd = {8'h00, s[7:0]};
            CBL_COPY_REGISTER_PAIR: {n.wide, n.wd} = {1'b1, s};
            CBL_LOAD_CONSTANT: n.wd = {8'h00, im};
            CBL_LOAD_INDIRECT: n.ma = p;
            CBL_LOAD_POST_INC: {n.ma, n.pwe, n.pwd} = {p, 1'b1, p + 16'h0001};
            CBL_LOAD_PRE_DEC: {n.ma, n.pwe, n.pwd} = {p - 16'h0001, 1'b1, p - 16'h0001};
            CBL_LOAD_OFFSET: n.ma = p + {10'h000, dq};
            default:
            begin
                n.tk = cond_of(o, flg);
                n.pct = p + {{9{k[6]}}, k} + 16'h0001;
                n.lat = n.tk ? 2 : 1;
            end
        endcase
        if (o >= CBL_LOAD_INDIRECT && o <= CBL_LOAD_OFFSET)
        begin
            n.mre = 1'b1;
            n.lat = 2;
            n.wd = {8'h00, n.ma[7:0] ^ n.ma[15:8] ^ 8'hA5};
        end
        @(posedge clk);
        start <= 1'b1;
        op <= o;
        {pc, ptr, offset, src_data, imm, disp, ptr_sel, dest} <= {p, p, k, s, im, dq, ps, n.wa};
        if (o != CBL_NOP)
            q.push_back(n);
        for (w = 0; w < 8; w++)
        begin
            @(negedge clk);
            if (ready === 1'b1)
                break;
        end
        if (w == 8)
            chk("ready", 17'h1, 17'(ready));
    endtask
    task automatic drain;
        int w;
        @(posedge clk);
        start <= 1'b0;
        for (w = 0; w < 20 && q.size() > 0; w++)
            @(posedge clk);
        chk("pending", 17'h0, 17'(q.size()));
    endtask
    task automatic set_flags(input logic [7:0] v);
        drain();
        alu_flag_we <= 1'b1;
        alu_flags <= v;
        @(posedge clk);
        alu_flag_we <= 1'b0;
        alu_flags <= ~v;
        flg = v;
    endtask
    always @(negedge clk)
    begin
        cbl_tb_note_type n;
        int a;
        cyc++;
        if (start && ready === 1'b1 && op != CBL_NOP)
            acc_q.push_back(cyc);
        if (mem_re === 1'b1)
            {seen_mre, seen_ma, seen_pwe, seen_pwd, seen_ps} = {1'b1, mem_addr, ptr_we, ptr_wdata, ptr_wsel};
        if (done === 1'b1)
        begin
            if (q.size() == 0 || acc_q.size() == 0)
                chk("unexpected done", 17'h0, 17'h1);
            else
            begin
                n = q.pop_front();
                a = acc_q.pop_front();
                chk("cycles", 17'(n.lat), 17'(cyc - a));
                chk("pc_load", 17'(n.tk), 17'(pc_load));
                if (n.tk)
                    chk("pc_target", 17'(n.pct), 17'(pc_target));
                chk("rf_we", 17'(n.rfw), 17'(rf_we));
                if (n.rfw)
                    chk("rf write", {n.wide, n.wd}, {rf_wide, rf_wdata});
                if (n.rfw)
                    chk("rf_waddr", 17'(n.wa), 17'(rf_waddr));
                chk("mem_re", 17'(n.mre), 17'(seen_mre));
                if (n.mre)
                    chk("mem_addr", 17'(n.ma), 17'(seen_ma));
                if (n.mre)
                    chk("ptr_we", 17'(n.pwe), 17'(seen_pwe));
                if (n.pwe)
                    chk("ptr_wsel", 17'(n.ps), 17'(seen_ps));
                if (n.pwe)
                    chk("ptr_wdata", 17'(n.pwd), 17'(seen_pwd));
                chk("flags", 17'(flg), 17'(flags));
                seen_mre = 1'b0;
            end
        end
    end
    initial
    begin
        #(8 * 20000);
        fails++;
        finish_test();
    end
    initial
    begin
        {reset, start, alu_flag_we, seen_mre} = 4'h8;
        {start, alu_flag_we} = 2'h0;
        {pc, ptr, src_data, offset, imm, disp, ptr_sel, dest, alu_flags} = '0;
        op = CBL_NOP;
        flg = 8'h00;
        seed = 32'hF0D6;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        for (i = 0; i < 40; i++)
        begin
            set_flags(i == 0 ? 8'hFF : (i == 1 ? 8'h00 : 8'($random(seed))));
            for (j = 16; j <= 26; j++)
                send(cbl_op_type'(j), 16'($random(seed)),
                    i[1:0] == 0 ? 7'h3F : (i[1:0] == 1 ? 7'h40 : 7'($random(seed))));
        end
        drain();
        $display("test branches done");
        set_flags(8'($random(seed)));
        // Back to back, so the next request is held while a load is busy
        for (i = 0; i < 70; i++)
            send(cbl_op_type'(1 + i % 7), i < 7 ? 16'hFFFF : (i < 14 ? 16'h0000 : 16'($random(seed))), 7'h00);
        drain();
        $display("test transfers done");
        send(CBL_NOP, 16'h1234, 7'h01);
        send(CBL_LOAD_PRE_DEC, 16'h0000, 7'h00);
        drain();
        $display("test idle op done");
        finish_test();
    end
endmodule
`default_nettype wire
